// ===== logic/conv_ctrl_pkg.sv
// Purpose: constants for the secondary converter control block
// Assumes: APB slave, 32-bit data, 40 MHz pclk
// Notes: offsets are byte addresses on the APB side
package conv_ctrl_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [11:0] ctrl_status_addr = 12'h000;
	localparam logic [11:0] irq_status_addr = 12'h004;
	localparam logic [11:0] irq_mask_addr = 12'h008;
	localparam logic [11:0] window_addr = 12'h00C;
	localparam logic [11:0] result_addr = 12'h010;
	// ****************************************
	// field positions of the control/status register
	// ****************************************
	localparam int enable_bit = 7;
	localparam int track_mode_bit = 6;
	localparam int done_bit = 5;
	localparam int busy_bit = 4;
	localparam int source_lsb = 1;
	localparam int window_flag_bit = 0;
	localparam logic [7:0] ctrl_reset = 8'h00;
	// ****************************************
	// start sources
	// ****************************************
	localparam logic [2:0] src_software = 3'h0;
	localparam logic [2:0] src_timer3 = 3'h1;
	localparam logic [2:0] src_strobe = 3'h2;
	localparam logic [2:0] src_timer2 = 3'h3;
	// ****************************************
	// timing
	// ****************************************
	localparam int track_clocks = 3;
	localparam int sar_bits = 8;
	localparam int sar_div_reset = 4;
	// interrupt bit positions: 0 done, 1 window
	localparam int irq_done = 0;
	localparam int irq_window = 1;
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_track = 2'b01,
		st_convert = 2'b10
	} conv_state_t;
endpackage

// ===== logic/pin_sync.sv
// Purpose: two-flop synchroniser for one pin
// Assumes: async input, pclk domain
// Notes: only the second stage is read outside
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
	input wire logic pclk, // clock
	input wire logic presetn, // async reset, low
	input wire logic async_in, // pin level
	output logic sync_out // synchronised level
);
	logic meta;
	// first stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end
endmodule
`default_nettype wire

// ===== logic/sar_clock_div.sv
// Purpose: converter clock tick from pclk
// Assumes: div value at least 1
// Notes: one pulse every div+1 pclk cycles
`timescale 1ns/1ps
`default_nettype none
module sar_clock_div #(
	parameter int W = 5
) (
	input wire logic pclk, // clock
	input wire logic presetn, // async reset, low
	input wire logic [W-1:0] div, // divide value
	input wire logic run, // count while high
	output logic tick // one-cycle converter tick
);
	logic [W-1:0] cnt;
	if (W < 1) begin : g_bad_width
		$error("divider width must be positive");
	end
	// restart when stopped so every conversion starts aligned
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= '0;
			tick <= 1'b0;
		end else if (!run) begin
			cnt <= '0;
			tick <= 1'b0;
		end else if (cnt >= div) begin
			cnt <= '0;
			tick <= 1'b1;
		end else begin
			cnt <= cnt + 1'b1;
			tick <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== logic/sar_adc_conversion_control.sv
// Purpose: start, track and status control of the secondary converter
// Assumes: APB slave, timers pulse one pclk on overflow
// Notes: analog path outside; result and comparator flags are inputs
//
// Operation
// - normal mode tracks unless converting
// - done flag sticky, software clears
// - busy reads one while converting
// - done set as busy falls
// - busy write one starts only source 000
// - normal mode source 000 software start
// - source 010 starts on strobe rise
// - source 011 starts on timer 2
// - source 1xx follows primary start
// - delayed mode tracks three clocks first
// - delayed 010 tracks while strobe low
// - window flag sticky until cleared
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_conversion_control
	import conv_ctrl_pkg::*;
#(
	parameter int DIV_W = 5
) (
	input wire logic pclk, // clock 40 MHz
	input wire logic presetn, // async reset, low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic ext_convert_strobe_a, // strobe pin a
	input wire logic ext_convert_strobe_b, // strobe pin b
	input wire logic timer2_overflow, // timer 2 pulse
	input wire logic timer3_overflow, // timer 3 pulse
	input wire logic primary_start, // primary busy write one pulse
	input wire logic [7:0] sar_result, // result from comparator array
	input wire logic window_hit, // window compare true for result
	output logic converter_power, // analog bias on
	output logic track_enable, // sample switch closed
	output logic convert_active, // sar running
	output logic result_valid, // one-cycle result strobe
	output logic irq // level interrupt
);
	import conv_ctrl_pkg::*;

	// ****************************************
	// declarations
	// ****************************************
	logic converter_enable;
	logic track_mode_select;
	logic conversion_done_flag;
	logic window_match_flag;
	logic [2:0] start_source_select;
	logic [DIV_W-1:0] sar_div;
	logic [1:0] irq_status;
	logic [1:0] irq_mask;
	logic [7:0] result;
	conv_state_t state;
	logic [3:0] step;
	logic sar_tick;
	logic strobe_a_s;
	logic strobe_b_s;
	logic strobe_any_d;
	logic strobe_any;
	logic strobe_rise;
	logic wr;
	logic rd;
	logic sw_start;
	logic start_req;
	logic done_event;
	logic window_event;
	logic conversion_busy;

	if (DIV_W < 1 || DIV_W > 8) begin : g_bad_div
		$error("DIV_W out of range");
	end

	// ****************************************
	// pin synchronisers and strobe edge
	// ****************************************
	pin_sync u_sync_a (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(ext_convert_strobe_a),
		.sync_out(strobe_a_s)
	);
	pin_sync u_sync_b (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(ext_convert_strobe_b),
		.sync_out(strobe_b_s)
	);
	// either strobe counts; rise of the combined level
	assign strobe_any = strobe_a_s | strobe_b_s;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strobe_any_d <= 1'b0;
		end else begin
			strobe_any_d <= strobe_any;
		end
	end
	assign strobe_rise = strobe_any & ~strobe_any_d;

	// ****************************************
	// bus decode
	// ****************************************
	assign wr = psel & penable & pwrite;
	assign rd = psel & ~penable & ~pwrite;
	// busy write one only starts from source 000; a disabling write never starts
	assign sw_start = wr && paddr == ctrl_status_addr
		&& pwdata[busy_bit] && pwdata[enable_bit]
		&& start_source_select == src_software;

	// start source selection
	always_comb begin
		start_req = 1'b0;
		if (start_source_select[2]) begin
			start_req = primary_start;
		end else begin
			case (start_source_select)
				src_software: start_req = sw_start;
				src_timer3: start_req = timer3_overflow;
				src_strobe: start_req = strobe_rise;
				src_timer2: start_req = timer2_overflow;
				default: start_req = 1'b0;
			endcase
		end
	end

	// ****************************************
	// conversion sequencer
	// ****************************************
	sar_clock_div #(
		.W(DIV_W)
	) u_div (
		.pclk(pclk),
		.presetn(presetn),
		.div(sar_div),
		.run(state != st_idle),
		.tick(sar_tick)
	);

	// strobe starts in delayed mode convert at once: tracking was the low phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= st_idle;
			step <= 4'h0;
		end else if (!converter_enable) begin
			state <= st_idle;
			step <= 4'h0;
		end else begin
			case (state)
				st_idle: begin
					step <= 4'h0;
					if (start_req) begin
						if (track_mode_select
							&& start_source_select != src_strobe) begin
							state <= st_track;
						end else begin
							state <= st_convert;
						end
					end
				end
				st_track: begin
					if (sar_tick) begin
						if (step == 4'(track_clocks - 1)) begin
							step <= 4'h0;
							state <= st_convert;
						end else begin
							step <= step + 4'h1;
						end
					end
				end
				st_convert: begin
					if (sar_tick) begin
						if (step == 4'(sar_bits - 1)) begin
							step <= 4'h0;
							state <= st_idle;
						end else begin
							step <= step + 4'h1;
						end
					end
				end
				default: begin
					state <= st_idle;
				end
			endcase
		end
	end
	assign conversion_busy = (state != st_idle);
	// busy falls on the edge after this cycle
	assign done_event = state == st_convert && sar_tick
		&& step == 4'(sar_bits - 1);
	assign window_event = done_event & window_hit;

	// ****************************************
	// analog control outputs
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			converter_power <= 1'b0;
			track_enable <= 1'b0;
			convert_active <= 1'b0;
			result_valid <= 1'b0;
		end else begin
			converter_power <= converter_enable;
			// drops with power on disable, on the same edge that state leaves convert
			convert_active <= converter_enable && state == st_convert;
			result_valid <= done_event;
			if (!converter_enable) begin
				track_enable <= 1'b0;
			end else if (!track_mode_select) begin
				track_enable <= state != st_convert;
			end else if (start_source_select == src_strobe) begin
				track_enable <= !strobe_any && state == st_idle;
			end else begin
				track_enable <= state == st_track;
			end
		end
	end

	// ****************************************
	// result capture
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result <= 8'h00;
		end else if (done_event) begin
			result <= sar_result;
		end
	end

	// ****************************************
	// control register
	// ****************************************
	// software may clear a flag by writing zero; an event that cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			converter_enable <= ctrl_reset[enable_bit];
			track_mode_select <= ctrl_reset[track_mode_bit];
			conversion_done_flag <= ctrl_reset[done_bit];
			window_match_flag <= ctrl_reset[window_flag_bit];
			start_source_select <= ctrl_reset[source_lsb +: 3];
		end else begin
			if (wr && paddr == ctrl_status_addr) begin
				converter_enable <= pwdata[enable_bit];
				track_mode_select <= pwdata[track_mode_bit];
				start_source_select <= pwdata[source_lsb +: 3];
			end
			if (done_event) begin
				conversion_done_flag <= 1'b1;
			end else if (wr && paddr == ctrl_status_addr) begin
				conversion_done_flag <= pwdata[done_bit];
			end
			if (window_event) begin
				window_match_flag <= 1'b1;
			end else if (wr && paddr == ctrl_status_addr) begin
				window_match_flag <= pwdata[window_flag_bit];
			end
		end
	end

	// divider and mask registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sar_div <= DIV_W'(sar_div_reset);
			irq_mask <= 2'h0;
		end else if (wr && paddr == window_addr) begin
			sar_div <= pwdata[DIV_W-1:0];
		end else if (wr && paddr == irq_mask_addr) begin
			irq_mask <= pwdata[1:0];
		end
	end

	// ****************************************
	// interrupt status, write one to clear
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if ((i == irq_done && done_event)
					|| (i == irq_window && window_event)) begin
					irq_status[i] <= 1'b1;
				end else if (wr && paddr == irq_status_addr && pwdata[i]) begin
					irq_status[i] <= 1'b0;
				end
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status & irq_mask);
		end
	end

	// ****************************************
	// apb read path, no wait state
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & ~penable;
			pslverr <= 1'b0;
			if (psel & ~penable) begin
				case (paddr)
					ctrl_status_addr, irq_status_addr, irq_mask_addr,
					window_addr, result_addr: pslverr <= 1'b0;
					default: pslverr <= 1'b1;
				endcase
			end
			if (rd) begin
				case (paddr)
					ctrl_status_addr: prdata <= {24'h000000,
						converter_enable, track_mode_select,
						conversion_done_flag, conversion_busy,
						start_source_select, window_match_flag};
					irq_status_addr: prdata <= {30'h0, irq_status};
					irq_mask_addr: prdata <= {30'h0, irq_mask};
					window_addr: prdata <= {{(32-DIV_W){1'b0}}, sar_div};
					result_addr: prdata <= {24'h000000, result};
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ===== bench/conv_ctrl_assertions.sv
// Purpose: port-level checks of the converter control block
// Assumes: control byte at offset 0, written over APB
// Notes: shadow holds the whole written control byte, flags set by hardware are ignored
`timescale 1ns/1ps
`default_nettype none
module conv_ctrl_assertions (
	input wire logic pclk, // clock
	input wire logic presetn, // reset, low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb address
	input wire logic [31:0] pwdata, // apb write data
	input wire logic pready, // apb ready
	input wire logic timer2_overflow, // timer 2 pulse
	input wire logic timer3_overflow, // timer 3 pulse
	input wire logic primary_start, // primary start pulse
	input wire logic converter_power, // bias on
	input wire logic track_enable, // sampling
	input wire logic convert_active, // sar running
	input wire logic result_valid, // result strobe
	input wire logic irq // interrupt
);
	logic wr;
	logic go;
	logic [7:0] sh;
	// control write, and idle in normal mode
	assign wr = psel && penable && pwrite && pready && paddr == 12'h000;
	assign go = sh[7] && !sh[6] && !convert_active;
	// shadow of the control byte
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh <= 8'h00;
		end else if (wr) begin
			sh <= pwdata[7:0];
		end
	end
	// ****************************************
	// properties
	// ****************************************
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_off;
		!converter_power |-> !convert_active && !track_enable;
	endproperty
	a_off: assert property (p_off)
		else $error("converter active while off");
	property p_pwr;
		wr |-> ##2 converter_power == $past(pwdata[7], 2);
	endproperty
	a_pwr: assert property (p_pwr)
		else $error("power does not follow enable");
	property p_hold;
		convert_active |-> !track_enable;
	endproperty
	a_hold: assert property (p_hold)
		else $error("tracking during conversion");
	// a few cycles of grace after a conversion ends
	property p_track;
		(converter_power && !sh[6] && !convert_active) [*3] |-> track_enable;
	endproperty
	a_track: assert property (p_track)
		else $error("normal mode idle without tracking");
	property p_len;
		$rose(convert_active) |-> convert_active [*8];
	endproperty
	a_len: assert property (p_len)
		else $error("conversion shorter than eight cycles");
	property p_done;
		$fell(convert_active) && converter_power |-> $past(result_valid);
	endproperty
	a_done: assert property (p_done)
		else $error("no result after conversion");
	property p_t2;
		go && sh[3:1] == 3'h3 && timer2_overflow |-> ##[1:3] convert_active;
	endproperty
	a_t2: assert property (p_t2)
		else $error("timer 2 start missed");
	property p_t3;
		go && sh[3:1] == 3'h1 && timer3_overflow |-> ##[1:3] convert_active;
	endproperty
	a_t3: assert property (p_t3)
		else $error("timer 3 start missed");
	property p_prim;
		go && sh[3] && primary_start |-> ##[1:3] convert_active;
	endproperty
	a_prim: assert property (p_prim)
		else $error("primary start missed");
	c_start: cover property ($rose(convert_active));
	c_res: cover property (result_valid);
	c_irq: cover property (irq);
endmodule
`default_nettype wire

// ===== bench/sar_adc_conversion_control_test.sv
// Purpose: self-checking bench of the converter control block
// Assumes: zero-wait APB, divider left at its reset value
// Notes: start sources run from a table, odd cases follow
`timescale 1ns/1ps
`default_nettype none
module sar_adc_conversion_control_test;
	typedef struct {logic [2:0] src; logic [5:0] trig; logic exp;} row_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic ext_convert_strobe_a, ext_convert_strobe_b, timer2_overflow;
	logic timer3_overflow, primary_start, window_hit, converter_power;
	logic track_enable, convert_active, result_valid, irq, er, seen, m0;
	logic [7:0] sar_result, c;
	int num_errors = 0;
	int checks = 0;
	int cyc = 0;
	// trig bits: software, primary, timer 2, timer 3, strobe a, strobe b
	row_t rows[10] = '{'{3'h0, 6'h20, 1'h1}, '{3'h0, 6'h08, 1'h0},
		'{3'h1, 6'h04, 1'h1}, '{3'h1, 6'h20, 1'h0}, '{3'h2, 6'h02, 1'h1},
		'{3'h2, 6'h01, 1'h1}, '{3'h3, 6'h08, 1'h1}, '{3'h3, 6'h04, 1'h0},
		'{3'h4, 6'h10, 1'h1}, '{3'h7, 6'h10, 1'h1}};
	sar_adc_conversion_control i_dut (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.ext_convert_strobe_a(ext_convert_strobe_a),
		.ext_convert_strobe_b(ext_convert_strobe_b),
		.timer2_overflow(timer2_overflow),
		.timer3_overflow(timer3_overflow),
		.primary_start(primary_start),
		.sar_result(sar_result),
		.window_hit(window_hit),
		.converter_power(converter_power),
		.track_enable(track_enable),
		.convert_active(convert_active),
		.result_valid(result_valid),
		.irq(irq)
	);
	// clock, and a ceiling well above the run length
	initial begin
		pclk = 1'h0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc > 20000) begin
			num_errors++;
			stop_test();
		end
	end
	// ****************************************
	// tasks
	// ****************************************
	task stop_test;
		if (num_errors == 0 && checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	// timers and primary start are one-cycle pulses, strobes stay up
	task pulse(input logic [4:0] t);
		@(posedge pclk);
		{primary_start, timer2_overflow, timer3_overflow} <= t[4:2];
		{ext_convert_strobe_a, ext_convert_strobe_b} <= t[1:0];
		@(posedge pclk);
		{primary_start, timer2_overflow, timer3_overflow} <= 3'h0;
	endtask
	task wres;
		seen = 1'h0;
		for (int k = 0; k < 150 && !seen; k++) begin
			@(posedge pclk);
			seen = result_valid === 1'h1;
		end
	endtask
	// ****************************************
	// sequence
	// ****************************************
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{ext_convert_strobe_a, ext_convert_strobe_b, window_hit} = 3'h0;
		{timer2_overflow, timer3_overflow, primary_start} = 3'h0;
		sar_result = 8'hA5;
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		apb(1'h0, 12'h000, 32'h0);
		chk(rd, 32'h0);
		apb(1'h0, 12'h00C, 32'h0);
		chk(rd, 32'h4);
		// one start source per row, wrong sources must not start
		foreach (rows[i]) begin
			c = {1'h1, 3'h0, rows[i].src, 1'h0};
			apb(1'h1, 12'h000, {24'h0, c});
			if (rows[i].trig[5]) apb(1'h1, 12'h000, {24'h0, c | 8'h10});
			else pulse(rows[i].trig[4:0]);
			wres();
			chk(32'(seen), 32'(rows[i].exp));
			apb(1'h0, 12'h000, 32'h0);
			chk(32'(rd[5]), 32'(rows[i].exp));
			ext_convert_strobe_a <= 1'h0;
			ext_convert_strobe_b <= 1'h0;
			apb(1'h1, 12'h000, {24'h0, c});
			apb(1'h1, 12'h004, 32'h3);
		end
		// busy while running, sticky flags, result, interrupt mask
		window_hit <= 1'h1;
		apb(1'h1, 12'h000, 32'h80);
		apb(1'h1, 12'h000, 32'h90);
		apb(1'h0, 12'h000, 32'h0);
		chk(32'(rd[4]), 32'h1);
		wres();
		repeat (20) @(posedge pclk);
		apb(1'h0, 12'h000, 32'h0);
		chk(rd, 32'hA1);
		apb(1'h0, 12'h010, 32'h0);
		chk(rd, 32'hA5);
		apb(1'h1, 12'h008, 32'h0);
		repeat (2) @(posedge pclk);
		m0 = irq;
		apb(1'h1, 12'h008, 32'h3);
		repeat (2) @(posedge pclk);
		chk(32'({m0, irq}), 32'h1);
		apb(1'h1, 12'h004, 32'h3);
		repeat (2) @(posedge pclk);
		chk(32'(irq), 32'h0);
		window_hit <= 1'h0;
		apb(1'h1, 12'h000, 32'h80);
		apb(1'h0, 12'h000, 32'h0);
		chk(rd, 32'h80);
		// disabled: a start write is lost
		apb(1'h1, 12'h000, 32'h10);
		wres();
		chk(32'({seen, converter_power}), 32'h0);
		// delayed mode tracks before converting
		apb(1'h1, 12'h000, 32'hC0);
		apb(1'h1, 12'h000, 32'hD0);
		repeat (3) @(posedge pclk);
		chk(32'({convert_active, track_enable}), 32'h1);
		repeat (12) @(posedge pclk);
		chk(32'({convert_active, track_enable}), 32'h1);
		repeat (3) @(posedge pclk);
		chk(32'({convert_active, track_enable}), 32'h2);
		wres();
		chk(32'(seen), 32'h1);
		// delayed strobe mode: track while low, convert on rise
		apb(1'h1, 12'h000, 32'hC4);
		repeat (4) @(posedge pclk);
		chk(32'(track_enable), 32'h1);
		ext_convert_strobe_a <= 1'h1;
		wres();
		repeat (2) @(posedge pclk);
		chk(32'({seen, track_enable}), 32'h2);
		ext_convert_strobe_a <= 1'h0;
		apb(1'h0, 12'h020, 32'h0);
		chk({er, rd[30:0]}, 32'h80000000);
		// reset in mid-conversion
		apb(1'h1, 12'h000, 32'h80);
		apb(1'h1, 12'h000, 32'h90);
		repeat (5) @(posedge pclk);
		chk(32'(convert_active), 32'h1);
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		chk(32'(convert_active), 32'h0);
		presetn <= 1'h1;
		apb(1'h0, 12'h000, 32'h0);
		chk(rd, 32'h0);
		stop_test();
	end
endmodule
bind sar_adc_conversion_control conv_ctrl_assertions i_chk (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .pwdata, .pready, .timer2_overflow,
	.timer3_overflow, .primary_start, .converter_power, .track_enable,
	.convert_active, .result_valid, .irq);
`default_nettype wire
